// ### pkg/opi_pkg.sv
// constants shared by the panel driver control block and its test bench
`default_nettype none
package opi_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_ADDR     = 8'h08;
  localparam logic [7:0] OFS_CONTRAST = 8'h0c;
  localparam logic [7:0] OFS_RAM_ADDR = 8'h10;
  localparam logic [7:0] OFS_RAM_DATA = 8'h14;
  // control register field positions and reset value
  localparam int         CTRL_PORT_EN = 0;
  localparam int         CTRL_SERIAL  = 1;
  localparam logic [1:0] CTRL_RST     = 2'h1;
  // status register field positions
  localparam int ST_DISP_ON  = 0;
  localparam int ST_ALL_ON   = 1;
  localparam int ST_INVERSE  = 2;
  localparam int ST_SEG_REMAP = 3;
  localparam int ST_COM_REV  = 4;
  localparam int ST_PUMP_EN  = 5;
  localparam int ST_PUMP_V   = 6;
  localparam int ST_MUX      = 8;
  localparam int ST_IN_RESET = 14;
  // address register field positions
  localparam int AD_COL   = 0;
  localparam int AD_PAGE  = 8;
  localparam int AD_START = 16;
  // state taken while the panel reset pin is low
  localparam logic [7:0] CONTRAST_RST  = 8'h7f;
  localparam logic [5:0] MUX_RST       = 6'h3f;
  localparam logic [1:0] PUMP_V_RST    = 2'h2;
  localparam logic       PUMP_EN_RST   = 1'b0;
  // command codes
  localparam logic [7:0] CMD_DISP_OFF  = 8'hae;
  localparam logic [7:0] CMD_DISP_ON   = 8'haf;
  localparam logic [7:0] CMD_CONTRAST  = 8'h81;
  localparam logic [7:0] CMD_MUX       = 8'ha8;
  localparam logic [7:0] CMD_PUMP      = 8'had;
  localparam logic [7:0] PUMP_EXT      = 8'h8a;
  localparam logic [7:0] PUMP_INT      = 8'h8b;
  localparam logic [7:0] CMD_REMAP_N   = 8'ha0;
  localparam logic [7:0] CMD_REMAP_R   = 8'ha1;
  localparam logic [7:0] CMD_RAM_SHOW  = 8'ha4;
  localparam logic [7:0] CMD_ALL_ON    = 8'ha5;
  localparam logic [7:0] CMD_NORMAL    = 8'ha6;
  localparam logic [7:0] CMD_INVERSE   = 8'ha7;
  localparam logic [7:0] CMD_OFFSET    = 8'hd3;
  localparam logic [7:0] CMD_OSC       = 8'hd5;
  localparam logic [7:0] CMD_PRECHG    = 8'hd9;
  localparam logic [7:0] CMD_COM_PINS  = 8'hda;
  localparam logic [7:0] CMD_VCOMH     = 8'hdb;
  // upper nibbles of the ranged commands; top two bits of the start line command
  localparam logic [3:0] NIB_COL_LO = 4'h0;
  localparam logic [3:0] NIB_COL_HI = 4'h1;
  localparam logic [3:0] NIB_PUMP_V = 4'h3;
  localparam logic [3:0] NIB_PAGE   = 4'hb;
  localparam logic [3:0] NIB_SCAN   = 4'hc;
  localparam logic [1:0] TOP_START  = 2'h1;
  // operand expected after a two-byte command
  typedef enum logic [2:0] {
    ARG_NONE, ARG_CONTRAST, ARG_MUX, ARG_PUMP, ARG_SKIP
  } opi_arg_e;
endpackage
`default_nettype wire

// ### logic/opi_ram.sv
// display memory: one write port, one read port with registered data
`default_nettype none
module opi_ram #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 1024,
  parameter int AW     = $clog2(DEPTH)
) (
  input  wire logic              sys_clk_i,
  input  wire logic              wr_en_i,
  input  wire logic [AW-1:0]     wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [AW-1:0]     rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || (1 << AW) < DEPTH) $error("opi_ram: bad depth");
  end

  // array contents have no reset; read data is one cycle behind address
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) mem[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// ### logic/opi_core.sv
// panel driver control: host byte port, command state, reset defaults, bus
`default_nettype none
//Contract
//- reset low: display off, 64-row mode
//- reset gives normal segment and row mapping
//- reset clears serial shift register
//- reset zeroes start line and column
//- reset gives normal common scan direction
//- reset loads contrast with 7fh
//- reset gives normal RAM-showing display
//- pump command adh then 8ah or 8bh
//- pump voltage chosen by 30h to 33h
module opi_core #(
  parameter int NUM_COLS  = 128,
  parameter int NUM_PAGES = 8
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        panel_reset_n_i,
  input  wire logic        chip_sel_n_i,
  input  wire logic        wr_strobe_n_i,
  input  wire logic        cmd_data_line_i,
  input  wire logic [7:0]  host_data_port_i,
  input  wire logic        ser_clk_i,
  input  wire logic        ser_data_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [31:0] hrdata_o,
  output logic             disp_on_o,
  output logic             all_on_o,
  output logic             inverse_o,
  output logic             seg_remap_o,
  output logic             com_rev_o,
  output logic      [7:0]  contrast_o,
  output logic      [5:0]  mux_ratio_o,
  output logic      [5:0]  start_line_o,
  output logic             pump_en_o,
  output logic      [1:0]  pump_volt_o
);
  localparam int AW = $clog2(NUM_COLS * NUM_PAGES);
  localparam int PW = $clog2(NUM_PAGES);

  initial begin
    if (NUM_COLS < 2 || NUM_COLS > 256) $error("opi_core: bad column count");
    if (NUM_PAGES < 2 || NUM_PAGES > 16) $error("opi_core: bad page count");
  end

  function automatic logic nib_is(input logic [7:0] b, input logic [3:0] n);
    return b[7:4] == n;
  endfunction

  // pins: two flops before use
  localparam int SW = 14;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic [SW-1:0] pin_prev;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= '1;
      pin_sync <= '1;
      pin_prev <= '1;
    end else begin
      pin_meta <= {panel_reset_n_i, chip_sel_n_i, wr_strobe_n_i,
                   cmd_data_line_i, host_data_port_i, ser_clk_i, ser_data_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire       prst_n   = pin_sync[13];
  wire       cs_n     = pin_sync[12];
  wire       dc_s     = pin_sync[10];
  wire [7:0] pdata    = pin_sync[9:2];
  wire       sdin     = pin_sync[0];
  wire       wr_rise  = pin_sync[11] & ~pin_prev[11];
  wire       sck_rise = pin_sync[1] & ~pin_prev[1];

  // software control register
  logic [1:0] ctrl;
  wire port_en = ctrl[opi_pkg::CTRL_PORT_EN];
  wire ser_sel = ctrl[opi_pkg::CTRL_SERIAL];

  // serial byte assembly
  logic [7:0] shreg;
  logic [2:0] sh_cnt;
  wire        ser_go   = ser_sel & ~cs_n & sck_rise;
  wire [7:0]  ser_byte = {shreg[6:0], sdin};
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shreg  <= '0;
      sh_cnt <= '0;
    end else if (!prst_n || cs_n) begin
      shreg  <= '0;
      sh_cnt <= '0;
    end else if (ser_go) begin
      shreg  <= ser_byte;
      sh_cnt <= sh_cnt + 3'h1;
    end
  end

  // one byte from either port; select line picks command or data
  wire       par_stb  = ~ser_sel & ~cs_n & wr_rise;
  wire       ser_stb  = ser_go & (sh_cnt == 3'h7);
  wire       byte_stb = prst_n & port_en & (par_stb | ser_stb);
  wire [7:0] byte_val = ser_sel ? ser_byte : pdata;
  wire       is_cmd   = byte_stb & ~dc_s;
  wire       is_dat   = byte_stb & dc_s;

  // operand tracking for two-byte commands
  opi_pkg::opi_arg_e arg_state;
  opi_pkg::opi_arg_e next_arg;
  always_comb begin
    next_arg = arg_state;
    if (is_cmd) begin
      case (arg_state)
        opi_pkg::ARG_NONE: begin
          case (byte_val)
            opi_pkg::CMD_CONTRAST: next_arg = opi_pkg::ARG_CONTRAST;
            opi_pkg::CMD_MUX:      next_arg = opi_pkg::ARG_MUX;
            opi_pkg::CMD_PUMP:     next_arg = opi_pkg::ARG_PUMP;
            opi_pkg::CMD_OFFSET, opi_pkg::CMD_OSC, opi_pkg::CMD_PRECHG,
            opi_pkg::CMD_COM_PINS, opi_pkg::CMD_VCOMH:
              next_arg = opi_pkg::ARG_SKIP;
            default:               next_arg = opi_pkg::ARG_NONE;
          endcase
        end
        default: next_arg = opi_pkg::ARG_NONE;
      endcase
    end
  end

  wire single   = is_cmd & (arg_state == opi_pkg::ARG_NONE);
  wire set_ctr  = is_cmd & (arg_state == opi_pkg::ARG_CONTRAST);
  wire set_mux  = is_cmd & (arg_state == opi_pkg::ARG_MUX);
  wire set_pump = is_cmd & (arg_state == opi_pkg::ARG_PUMP) &
                  (byte_val == opi_pkg::PUMP_EXT ||
                   byte_val == opi_pkg::PUMP_INT);
  wire set_pv   = single & nib_is(byte_val, opi_pkg::NIB_PUMP_V) &
                  (byte_val[3:2] == 2'h0);
  wire set_cl   = single & nib_is(byte_val, opi_pkg::NIB_COL_LO);
  wire set_ch   = single & nib_is(byte_val, opi_pkg::NIB_COL_HI);
  wire set_pg   = single & nib_is(byte_val, opi_pkg::NIB_PAGE) &
                  (32'(byte_val[3:0]) < NUM_PAGES);
  wire set_scan = single & nib_is(byte_val, opi_pkg::NIB_SCAN);
  wire set_sl   = single & (byte_val[7:6] == opi_pkg::TOP_START);

  // column and page pointers; data bytes fill memory and advance column
  logic [7:0]    col;
  logic [PW-1:0] page;
  wire           col_ok  = 32'(col) < NUM_COLS;
  wire           ram_we  = is_dat & col_ok;
  wire [AW-1:0]  ram_wa  = AW'(page) * AW'(NUM_COLS) + AW'(col);
  wire [7:0]     next_col = set_cl ? {col[7:4], byte_val[3:0]} :
                            set_ch ? {byte_val[3:0], col[3:0]} :
                            (is_dat && col != 8'hff) ? col + 8'h01 : col;

  // command state; panel reset pin holds every field at its default
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arg_state <= opi_pkg::ARG_NONE;
      disp_on_o <= 1'b0;
      mux_ratio_o <= opi_pkg::MUX_RST;
      seg_remap_o <= 1'b0;
      col <= '0;
      page <= '0;
      start_line_o <= '0;
      com_rev_o <= 1'b0;
      contrast_o <= opi_pkg::CONTRAST_RST;
      all_on_o <= 1'b0;
      inverse_o <= 1'b0;
      pump_en_o <= opi_pkg::PUMP_EN_RST;
      pump_volt_o <= opi_pkg::PUMP_V_RST;
    end else if (!prst_n) begin
      arg_state <= opi_pkg::ARG_NONE;
      disp_on_o <= 1'b0;
      mux_ratio_o <= opi_pkg::MUX_RST;
      seg_remap_o <= 1'b0;
      col <= '0;
      page <= '0;
      start_line_o <= '0;
      com_rev_o <= 1'b0;
      contrast_o <= opi_pkg::CONTRAST_RST;
      all_on_o <= 1'b0;
      inverse_o <= 1'b0;
      pump_en_o <= opi_pkg::PUMP_EN_RST;
      pump_volt_o <= opi_pkg::PUMP_V_RST;
    end else begin
      arg_state <= next_arg;
      col <= next_col;
      if (set_pg) page <= byte_val[PW-1:0];
      if (set_sl) start_line_o <= byte_val[5:0];
      if (set_scan) com_rev_o <= byte_val[3];
      if (set_ctr) contrast_o <= byte_val;
      if (set_mux) mux_ratio_o <= byte_val[5:0];
      if (set_pump) pump_en_o <= byte_val[0];
      if (set_pv) pump_volt_o <= byte_val[1:0];
      if (single) begin
        case (byte_val)
          opi_pkg::CMD_DISP_OFF: disp_on_o <= 1'b0;
          opi_pkg::CMD_DISP_ON:  disp_on_o <= 1'b1;
          opi_pkg::CMD_REMAP_N:  seg_remap_o <= 1'b0;
          opi_pkg::CMD_REMAP_R:  seg_remap_o <= 1'b1;
          opi_pkg::CMD_RAM_SHOW: all_on_o <= 1'b0;
          opi_pkg::CMD_ALL_ON:   all_on_o <= 1'b1;
          opi_pkg::CMD_NORMAL:   inverse_o <= 1'b0;
          opi_pkg::CMD_INVERSE:  inverse_o <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // display memory, read back by software through the ram window
  logic [AW-1:0] ram_ra;
  logic [7:0]    ram_rd;
  opi_ram #(.DATA_W(8), .DEPTH(NUM_COLS * NUM_PAGES)) u_ram (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (ram_we),
    .wr_addr_i (ram_wa),
    .wr_data_i (byte_val),
    .rd_addr_i (ram_ra),
    .rd_data_o (ram_rd)
  );

  // bus slave: zero wait states, always okay
  wire       ap_take = hsel_i & hready_i & htrans_i[1];
  logic      dp_wr;
  logic [7:0] dp_addr;
  wire       wr_ctrl = dp_wr & (dp_addr == opi_pkg::OFS_CTRL);
  wire       wr_ra   = dp_wr & (dp_addr == opi_pkg::OFS_RAM_ADDR);
  wire [31:0] st_word =
    32'({~prst_n, mux_ratio_o, pump_volt_o, pump_en_o, com_rev_o,
         seg_remap_o, inverse_o, all_on_o, disp_on_o});
  wire [31:0] ad_word = (32'(start_line_o) << opi_pkg::AD_START) |
                        (32'(page) << opi_pkg::AD_PAGE) |
                        (32'(col) << opi_pkg::AD_COL);
  wire [31:0] rd_mux =
    (haddr_i[7:0] == opi_pkg::OFS_CTRL)     ? 32'(ctrl) :
    (haddr_i[7:0] == opi_pkg::OFS_STATUS)   ? st_word :
    (haddr_i[7:0] == opi_pkg::OFS_ADDR)     ? ad_word :
    (haddr_i[7:0] == opi_pkg::OFS_CONTRAST) ? 32'(contrast_o) :
    (haddr_i[7:0] == opi_pkg::OFS_RAM_ADDR) ? 32'(ram_ra) :
    (haddr_i[7:0] == opi_pkg::OFS_RAM_DATA) ? 32'(ram_rd) : 32'h0;
  wire hi_zero = haddr_i[31:8] == 24'h0;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= '0;
      dp_wr <= 1'b0;
      dp_addr <= '0;
      ctrl <= opi_pkg::CTRL_RST;
      ram_ra <= '0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      dp_wr <= ap_take & hwrite_i & hi_zero;
      dp_addr <= haddr_i[7:0];
      if (ap_take && !hwrite_i) hrdata_o <= hi_zero ? rd_mux : 32'h0;
      if (wr_ctrl) ctrl <= hwdata_i[1:0];
      if (wr_ra) ram_ra <= hwdata_i[AW-1:0];
    end
  end

  // checks on reset defaults and pump commands
  property p_rst_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !prst_n |=> !disp_on_o && mux_ratio_o == 6'h3f;
  endproperty
  a_rst_off: assert property (p_rst_off)
    else $error("display not off in 64-row mode under reset");

  property p_rst_map;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !prst_n ##1 !prst_n |-> !seg_remap_o && ram_wa == '0;
  endproperty
  a_rst_map: assert property (p_rst_map)
    else $error("mapping not normal under reset");

  property p_rst_shift;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !prst_n |=> shreg == 8'h00 && sh_cnt == 3'h0;
  endproperty
  a_rst_shift: assert property (p_rst_shift)
    else $error("serial shift register not cleared");

  property p_rst_addr;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(prst_n) |=> start_line_o == 6'h0 && col == 8'h00;
  endproperty
  a_rst_addr: assert property (p_rst_addr)
    else $error("start line or column not zero after reset");

  property p_rst_scan;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !prst_n |=> !com_rev_o;
  endproperty
  a_rst_scan: assert property (p_rst_scan)
    else $error("common scan reversed under reset");

  property p_rst_ctr;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !prst_n [*2] |-> ##1 contrast_o == 8'h7f;
  endproperty
  a_rst_ctr: assert property (p_rst_ctr)
    else $error("contrast not 7fh under reset");

  property p_rst_norm;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !prst_n |=> !all_on_o && !inverse_o;
  endproperty
  a_rst_norm: assert property (p_rst_norm)
    else $error("display not in normal mode under reset");

  property p_pump;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    prst_n && is_cmd && arg_state == opi_pkg::ARG_PUMP &&
      byte_val[7:1] == 7'h45 |=> pump_en_o == $past(byte_val[0]);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump enable not taken from second byte");

  property p_pump_v;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    prst_n && single && byte_val == 8'h33 |=> pump_volt_o == 2'h3;
  endproperty
  a_pump_v: assert property (p_pump_v)
    else $error("pump voltage 33h not applied");
endmodule
`default_nettype wire

// ### bench/opi_host_model.sv
// host side model: panel reset pin, parallel byte port and serial pins
`default_nettype none
module opi_host_model (
  input  wire logic       sys_clk_i,
  output var  logic       panel_reset_n_o,
  output var  logic       chip_sel_n_o,
  output var  logic       wr_strobe_n_o,
  output var  logic       cmd_data_line_o,
  output var  logic [7:0] host_data_port_o,
  output var  logic       ser_clk_o,
  output var  logic       ser_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // supply switches; a low panel enable leaves that rail floating
  logic logic_rail_on;
  logic panel_rail_en;
  // idle pins at time zero; serial clock rests low outside frames
  initial begin
    logic_rail_on    = 1'b0;
    panel_rail_en    = 1'b0;
    panel_reset_n_o  = 1'b1;
    chip_sel_n_o     = 1'b1;
    wr_strobe_n_o    = 1'b1;
    cmd_data_line_o  = 1'b0;
    host_data_port_o = 8'h5a;
    ser_clk_o        = 1'b0;
    ser_data_o       = 1'b0;
  end
  // every pin level stays three clocks so the synchroniser sees it
  task automatic hold();
    repeat (3) @(posedge sys_clk_i);
  endtask
  // set both rails; the logic rail never drops while the panel rail is on
  task automatic rails(input logic lg, input logic pn);
    logic_rail_on <= lg | pn;
    panel_rail_en <= pn;
    repeat (3) hold();        // settle wait, scaled down to a few clocks
  endtask
  // drive the panel reset pin to a level and keep it there
  task automatic rst_lvl(input logic lvl);
    panel_reset_n_o <= lvl;
    repeat (3) hold();
  endtask
  // high, low, high before the first command
  task automatic reset_pulse();
    rst_lvl(1'b1);
    rst_lvl(1'b0);
    rst_lvl(1'b1);
  endtask
  // one strobed byte; select low for a command, high for data
  task automatic put(input logic dc, input logic [7:0] b);
    cmd_data_line_o  <= dc;
    chip_sel_n_o     <= 1'b0;
    host_data_port_o <= b;
    hold();
    wr_strobe_n_o <= 1'b0;
    hold();
    wr_strobe_n_o <= 1'b1;
    hold();
    chip_sel_n_o     <= 1'b1;
    host_data_port_o <= ~b; // released port shows no stale byte
    hold();
  endtask
  // n command bits msb first; a whole byte ends the frame
  task automatic ser_bits(input int n, input logic [7:0] v);
    chip_sel_n_o    <= 1'b0;
    cmd_data_line_o <= 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      ser_data_o <= v[i];
      ser_clk_o  <= 1'b0;
      hold();
      ser_clk_o <= 1'b1;
      hold();
    end
    ser_clk_o  <= 1'b0;
    ser_data_o <= ~v[0];
    if (n == 8)
      chip_sel_n_o <= 1'b1;
    hold();
  endtask
endmodule
`default_nettype wire

// ### bench/opi_core_test.sv
// self-checking bench for the panel driver control block
`default_nettype none
module opi_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, rst_b, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready, hresp, pr_n, cs_n, wr_n, dcl, sck, sda;
  wire logic   disp_on, all_on, inverse, seg_remap, com_rev, pump_en;
  wire logic [7:0]  port, contrast;
  wire logic [31:0] hrdata;
  wire logic [5:0]  mux, start;
  wire logic [1:0]  volt;
  int mismatches, compares, arg;
  int e_disp, e_all, e_inv, e_seg, e_com, e_con, e_mux, e_start;
  int e_pen, e_pv, e_col, e_page;
  int ram[int];
  opi_host_model host (.sys_clk_i(sys_clk), .panel_reset_n_o(pr_n),
    .chip_sel_n_o(cs_n), .wr_strobe_n_o(wr_n), .cmd_data_line_o(dcl),
    .host_data_port_o(port), .ser_clk_o(sck), .ser_data_o(sda));
  opi_core uut (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .panel_reset_n_i(pr_n), .chip_sel_n_i(cs_n), .wr_strobe_n_i(wr_n),
    .cmd_data_line_i(dcl), .host_data_port_i(port), .ser_clk_i(sck),
    .ser_data_i(sda), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .disp_on_o(disp_on), .all_on_o(all_on),
    .inverse_o(inverse), .seg_remap_o(seg_remap), .com_rev_o(com_rev),
    .contrast_o(contrast), .mux_ratio_o(mux), .start_line_o(start),
    .pump_en_o(pump_en), .pump_volt_o(volt));
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one single transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] mask, input string n);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(n, r & mask, exp);
  endtask
  // expected state after either reset
  task automatic dflt();
    {e_disp, e_all, e_inv, e_seg, e_com, e_pen, e_start} = '0;
    {e_col, e_page, arg} = '0;
    e_con = 'h7f;
    e_mux = 63;
    e_pv  = 2;
  endtask
  // reference decoder of one command byte
  task automatic model(input int b);
    if (arg == 1) e_con = b;
    if (arg == 2) e_mux = b % 64;
    if (arg == 3 && b inside {'h8a, 'h8b}) e_pen = b % 2;
    if (arg != 0) begin
      arg = 0;
      return;
    end
    if (b == 'h81) arg = 1;
    else if (b == 'ha8) arg = 2;
    else if (b == 'had) arg = 3;
    else if (b inside {'hd3, 'hd5, 'hd9, 'hda, 'hdb}) arg = 4;
    else if (b / 2 == 'h57) e_disp = b % 2;
    else if (b / 2 == 'h52) e_all = b % 2;
    else if (b / 2 == 'h53) e_inv = b % 2;
    else if (b / 2 == 'h50) e_seg = b % 2;
    else if (b / 16 == 'hc) e_com = b / 8 % 2;
    else if (b / 4 == 'hc) e_pv = b % 4;
    else if (b / 16 == 0) e_col = e_col / 16 * 16 + b % 16;
    else if (b / 16 == 1) e_col = e_col % 16 + b % 16 * 16;
    else if (b / 16 == 'hb) e_page = b % 16;
    else if (b / 64 == 1) e_start = b % 64;
  endtask
  task automatic cmd(input int b);
    host.put(1'b0, b[7:0]);
    model(b);
  endtask
  function automatic logic [31:0] st(input int r);
    return e_disp | e_all << 1 | e_inv << 2 | e_seg << 3 | e_com << 4
      | e_pen << 5 | e_pv << 6 | e_mux << 8 | r << 14;
  endfunction
  // all display state outputs against the reference
  task automatic chk_outs();
    chk("disp_on", disp_on, e_disp);
    chk("all_on", all_on, e_all);
    chk("inverse", inverse, e_inv);
    chk("seg_remap", seg_remap, e_seg);
    chk("com_rev", com_rev, e_com);
    chk("contrast", contrast, e_con);
    chk("mux", mux, e_mux);
    chk("start", start, e_start);
    chk("pump_en", pump_en, e_pen);
    chk("pump_volt", volt, e_pv);
  endtask
  // hang guard
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end
  initial begin
    int q[$];
    int a;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    rst_b = 1'b0;
    void'($urandom(32'h355a));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    dflt();
    chk_outs();
    rd(opi_pkg::OFS_CTRL, 32'h1, 32'hffffffff, "ctrl");
    rd(opi_pkg::OFS_ADDR, 32'h0, 32'h003f00ff, "addr");
    wr(8'h18, $urandom);
    rd(8'h18, 32'h0, 32'hffffffff, "unmapped");
    $display("test reset defaults done");
    host.rails(1'b1, 1'b0);
    host.reset_pulse();
    q = '{'hae, 'h02, 'h10, 'h40, 'hb0, 'h81, 0, 'ha1, 'ha6, 'ha8,
          'h3f, 'had, 'h8a, 'h32, 'hc8, 'hd3, 'h00, 'hd5, 'h80, 'hd9,
          'h22, 'hda, 'h12, 'hdb, 'h40};
    q[6] = $urandom % 256;
    foreach (q[i]) cmd(q[i]);
    host.rails(1'b1, 1'b1);
    cmd('haf);
    chk_outs();
    rd(opi_pkg::OFS_STATUS, st(0), 32'h7fff, "status");
    $display("test init sequence done");
    q = '{'ha5, 'ha7, 'ha0, 'hc0, 'had, 'h8b, 'h33, 'had, 'h55, 'ha4,
          'ha6, 'ha1, 'hc8, 'h30};
    foreach (q[i]) begin
      cmd(q[i]);
      chk_outs();
    end
    $display("test mode commands done");
    q = '{'h05, 'h10, 'hb1, 'h40 + $urandom % 64};
    foreach (q[i]) cmd(q[i]);
    for (int i = 0; i < 3; i++) begin
      a = $urandom % 256;
      host.put(1'b1, a[7:0]);
      ram[e_page * 128 + e_col] = a;
      e_col++;
    end
    rd(opi_pkg::OFS_ADDR, e_col | e_page << 8 | e_start << 16,
       32'h003fffff, "addr");
    foreach (ram[k]) begin
      wr(opi_pkg::OFS_RAM_ADDR, k);
      repeat (2) @(posedge sys_clk);
      rd(opi_pkg::OFS_RAM_DATA, ram[k], 32'hff, "ram");
    end
    wr(opi_pkg::OFS_CTRL, 32'h0);
    host.put(1'b0, 8'hae);
    chk_outs();
    wr(opi_pkg::OFS_CTRL, 32'h1);
    $display("test data bytes done");
    host.rst_lvl(1'b0);
    dflt();
    chk_outs();
    rd(opi_pkg::OFS_STATUS, st(1), 32'h7fff, "status");
    rd(opi_pkg::OFS_ADDR, 32'h0, 32'h003fffff, "addr");
    host.rst_lvl(1'b1);
    $display("test panel reset done");
    wr(opi_pkg::OFS_CTRL, 32'h3);
    host.ser_bits(3, 8'hff);
    host.rst_lvl(1'b0);
    host.rst_lvl(1'b1);
    host.ser_bits(8, 8'haf);
    model('haf);
    chk_outs();
    wr(opi_pkg::OFS_CTRL, 32'h1);
    $display("test serial clear done");
    cmd('hae);
    chk_outs();
    host.rails(1'b1, 1'b0);
    host.rails(1'b0, 1'b0);
    $display("test power down done");
    complete_run();
  end
endmodule
`default_nettype wire
